// ==== pkg/pts_defines.svh ====
// width, depth, latency and register constants for the timestamp side-band ports
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH
`define PTS_TS_W        80
`define PTS_TAG_W       16
`define PTS_ADJ_W       11
`define PTS_RXTS_W      64
`define PTS_TAGQ_DEPTH  8
`define PTS_TAGQ_AW     3
`define PTS_PIPE_LAT    4
`define PTS_TC_ADJ_REC  11'd802
`define PTS_REG_CTRL    4'h0
`define PTS_REG_STAT    4'h1
`define PTS_REG_MASK    4'h2
`define PTS_REG_TS_LO   4'h3
`define PTS_REG_TAG     4'h4
`define PTS_REG_ADJ     4'h5
`define PTS_REG_RXTS_LO 4'h6
`define PTS_CTRL_TC_BIT 0
`define PTS_CTRL_1S_BIT 1
`endif

// ==== pkg/pts_pkg.sv ====
// shared types for the timestamp side-band ports
package pts_pkg;
   typedef enum logic [1:0]
   {
      PTS_OP_NONE  = 2'h0,
      PTS_OP_ONE   = 2'h1,
      PTS_OP_TWO   = 2'h2,
      PTS_OP_RSVD  = 2'h3
   } pts_op_t;
endpackage : pts_pkg

// ==== pkg/pts_if.sv ====
// link between the stamping device end and the client end
`include "pts_defines.svh"
interface pts_if;
   // transmit side
   logic                     tx_sop;
   logic [1:0]               tx_stamp_action_in;
   logic [`PTS_TAG_W-1:0]    tx_tag;
   logic [`PTS_ADJ_W-1:0]    tx_lat_adj;
   logic [`PTS_RXTS_W-1:0]   tx_ingress_ts;
   logic                     tc_mode;
   logic                     one_step_en;
   logic [`PTS_TS_W-1:0]     tx_timer;
   logic                     tx_ts_valid;
   logic [`PTS_TAG_W-1:0]    tx_ts_tag;
   logic [`PTS_TS_W-1:0]     tx_ts;
   logic [`PTS_TS_W-1:0]     tx_ins_value;
   logic                     tx_ins_valid;
   logic                     tag_wr_err;
   logic                     tag_rd_err;
   // receive side
   logic                     rx_sop;
   logic [`PTS_TS_W-1:0]     rx_timer;
   logic [`PTS_TS_W-1:0]     rx_ts;
   logic                     rx_ts_valid;
   modport dev
   (
      input  tx_sop, tx_stamp_action_in, tx_tag, tx_lat_adj, tx_ingress_ts, tc_mode,
      input  one_step_en, tx_timer, rx_sop, rx_timer,
      output tx_ts_valid, tx_ts_tag, tx_ts, tx_ins_value, tx_ins_valid, tag_wr_err,
      output tag_rd_err, rx_ts, rx_ts_valid
   );
   modport cli
   (
      output tx_sop, tx_stamp_action_in, tx_tag, tx_lat_adj, tx_ingress_ts, tc_mode,
      output one_step_en, tx_timer, rx_sop, rx_timer,
      input  tx_ts_valid, tx_ts_tag, tx_ts, tx_ins_value, tx_ins_valid, tag_wr_err,
      input  tag_rd_err, rx_ts, rx_ts_valid
   );
endinterface : pts_if

// ==== design/pts_dev.sv ====
// device end: transmit tagging, stamp return, correction and receive stamps
//
// The placing of the registers and strobed register access were decided locally.
`include "pts_defines.svh"
// Functional notes
// - client holds tag valid on first cycle
// - no-operation frames ignore the tag
// - return captured tag with frame stamp
// - one-step stamp offset by latency adjust
// - client uses 802 in transparent mode
// - tag write error sticks until reset
// - tag read error sticks until reset
// - ingress stamp ignored unless transparent one-step
// - client formats ingress stamp bit fields
// - residence time added two's complement
// - client supplies receive timer, same format
// - receive stamp sampled at packet start
// - action code 11 behaves as none
// - transparent mode timer is correction value
// - valid strobe with each returned stamp
module pts_dev
   import pts_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // link to client
   pts_if.dev        lnk,
   // pacing of the internal capture plane: egress sop reaching it
   input  wire logic cap_plane
);
   // tag queue storage, in frame order
   logic [`PTS_TAG_W-1:0]   tagq_mem [`PTS_TAGQ_DEPTH];
   logic                    kindq_mem [`PTS_TAGQ_DEPTH];
   logic [`PTS_RXTS_W-1:0]  ingq_mem [`PTS_TAGQ_DEPTH];
   logic [`PTS_TAGQ_AW-1:0] wp_q;
   logic [`PTS_TAGQ_AW-1:0] rp_q;
   logic [`PTS_TAGQ_AW:0]   cnt_q;
   logic                    wr_err_q;
   logic                    rd_err_q;
   logic                    ts_valid_q;
   logic [`PTS_TAG_W-1:0]   ts_tag_q;
   logic [`PTS_TS_W-1:0]    ts_q;
   logic [`PTS_TS_W-1:0]    ins_q;
   logic                    ins_valid_q;
   logic [`PTS_TS_W-1:0]    rx_ts_q;
   logic                    rx_v_q;

   // action decode; reserved code falls to none
   pts_op_t op;
   wire     is_one;
   wire     is_two;
   wire     push_req;
   wire     full;
   wire     empty;
   wire     push;
   wire     pop;
   wire     pop_one;
   assign op       = pts_op_t'(lnk.tx_stamp_action_in);
   assign is_one   = (op == PTS_OP_ONE) && lnk.one_step_en;
   assign is_two   = (op == PTS_OP_TWO);
   assign push_req = lnk.tx_sop && (is_one || is_two);
   assign full     = (cnt_q == (`PTS_TAGQ_AW+1)'(`PTS_TAGQ_DEPTH));
   assign empty    = (cnt_q == '0);
   assign push     = push_req && !full;
   assign pop      = cap_plane && !empty;
   assign pop_one  = kindq_mem[rp_q];

   // one-step stamp: timer plus latency adjust, ns in [10:3], frac ns in [2:0]
   wire [`PTS_TS_W-1:0] adj_ext;
   wire [`PTS_TS_W-1:0] stamp_1s;
   wire [`PTS_TS_W-1:0] ingress_ext;
   wire [`PTS_TS_W-1:0] resid;
   assign adj_ext     = {{(`PTS_TS_W-`PTS_ADJ_W-13){1'b0}}, lnk.tx_lat_adj, 13'h0000};
   assign stamp_1s    = lnk.tx_timer + adj_ext;
   assign ingress_ext = {{(`PTS_TS_W-`PTS_RXTS_W){1'b0}}, ingq_mem[rp_q]};
   // transparent: timer is a correction value; residence = tx - ingress
   assign resid       = stamp_1s - ingress_ext;

   // queue write: tag captured at sop; ingress kept only for transparent one-step
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         tagq_mem[wp_q]  <= lnk.tx_tag;
         kindq_mem[wp_q] <= is_one;
         ingq_mem[wp_q]  <= (is_one && lnk.tc_mode) ? lnk.tx_ingress_ts : '0;
      end
   end

   // pointers and sticky error flags; only reset clears the flags
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wp_q     <= '0;
         rp_q     <= '0;
         cnt_q    <= '0;
         wr_err_q <= 1'b0;
         rd_err_q <= 1'b0;
      end
      else
      begin
         wp_q     <= push ? wp_q + 1'b1 : wp_q;
         rp_q     <= pop ? rp_q + 1'b1 : rp_q;
         cnt_q    <= cnt_q + (`PTS_TAGQ_AW+1)'(push) - (`PTS_TAGQ_AW+1)'(pop);
         wr_err_q <= wr_err_q | (push_req && full);
         rd_err_q <= rd_err_q | (cap_plane && empty);
      end
   end

   // result outputs: every popped stamp goes back to client, one-step also feeds insertion
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ts_valid_q  <= 1'b0;
         ts_tag_q    <= '0;
         ts_q        <= '0;
         ins_q       <= '0;
         ins_valid_q <= 1'b0;
      end
      else
      begin
         ts_valid_q  <= pop;
         ins_valid_q <= pop && pop_one;
         if (pop)
         begin
            ts_tag_q <= tagq_mem[rp_q];
            ts_q     <= pop_one ? stamp_1s : lnk.tx_timer;
            ins_q    <= lnk.tc_mode ? resid : stamp_1s;
         end
      end
   end

   // receive stamp taken at sop, presented in the cycle after the sop
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rx_ts_q <= '0;
         rx_v_q  <= 1'b0;
      end
      else
      begin
         rx_v_q <= lnk.rx_sop;
         if (lnk.rx_sop)
            rx_ts_q <= lnk.rx_timer;
      end
   end

   assign lnk.tx_ts_valid  = ts_valid_q;
   assign lnk.tx_ts_tag    = ts_tag_q;
   assign lnk.tx_ts        = ts_q;
   assign lnk.tx_ins_value = ins_q;
   assign lnk.tx_ins_valid = ins_valid_q;
   assign lnk.tag_wr_err   = wr_err_q;
   assign lnk.tag_rd_err   = rd_err_q;
   assign lnk.rx_ts        = rx_ts_q;
   assign lnk.rx_ts_valid  = rx_v_q;
endmodule : pts_dev

// ==== design/pts_cli.sv ====
// client end: register port, frame tagging, stamp collection, interrupt
`include "pts_defines.svh"
module pts_cli
   import pts_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // software register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   output logic             irq,
   // frame source and timers
   input  wire logic        frame_sop,
   input  wire logic [`PTS_TS_W-1:0] tx_timer_in,
   input  wire logic [`PTS_TS_W-1:0] rx_timer_in,
   input  wire logic        rx_frame_sop,
   // link to device
   pts_if.cli               lnk
);
   logic [31:0]            ctrl_q;
   logic [3:0]             stat_q;
   logic [3:0]             mask_q;
   logic [`PTS_TAG_W-1:0]  tag_q;
   logic [`PTS_ADJ_W-1:0]  adj_q;
   logic [`PTS_TS_W-1:0]   got_ts_q;
   logic [`PTS_TAG_W-1:0]  got_tag_q;
   logic [`PTS_TS_W-1:0]   got_rx_q;
   logic [31:0]            rdata_q;

   // control word: [0] transparent, [1] one-step enable, [3:2] action, upper bits unused
   wire [1:0] act;
   wire [3:0] ev;
   assign act = ctrl_q[3:2];
   // events: stamp back, rx stamp, write error, read error
   assign ev  = {lnk.tag_rd_err, lnk.tag_wr_err, lnk.rx_ts_valid, lnk.tx_ts_valid};

   // drive the link; tag held for the sop cycle, stepping at the edge that ends it
   assign lnk.tx_sop             = frame_sop;
   assign lnk.tx_stamp_action_in = act;
   assign lnk.tx_tag             = tag_q;
   assign lnk.tx_lat_adj         = adj_q;
   assign lnk.tx_ingress_ts      = {1'b0, got_rx_q[62:0]};
   assign lnk.tc_mode            = ctrl_q[`PTS_CTRL_TC_BIT];
   assign lnk.one_step_en        = ctrl_q[`PTS_CTRL_1S_BIT];
   assign lnk.tx_timer           = tx_timer_in;
   assign lnk.rx_sop             = rx_frame_sop;
   assign lnk.rx_timer           = rx_timer_in;

   // register writes; tag increments after each sop so frames are distinct
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ctrl_q <= '0;
         mask_q <= '0;
         tag_q  <= '0;
         adj_q  <= `PTS_TC_ADJ_REC;
      end
      else
      begin
         if (wr && addr == `PTS_REG_CTRL)
            ctrl_q <= wdata;
         if (wr && addr == `PTS_REG_MASK)
            mask_q <= wdata[3:0];
         if (wr && addr == `PTS_REG_ADJ)
            adj_q <= wdata[`PTS_ADJ_W-1:0];
         if (wr && addr == `PTS_REG_TAG)
            tag_q <= wdata[`PTS_TAG_W-1:0];
         else if (frame_sop)
            tag_q <= tag_q + 1'b1;
      end
   end

   // sticky status, set wins over write-one-to-clear
   wire [3:0] clr;
   assign clr = (wr && addr == `PTS_REG_STAT) ? wdata[3:0] : 4'h0;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         stat_q <= '0;
      else
         stat_q <= (stat_q & ~clr) | ev;
   end

   // capture returned and received stamps
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         got_ts_q  <= '0;
         got_tag_q <= '0;
         got_rx_q  <= '0;
      end
      else
      begin
         if (lnk.tx_ts_valid)
         begin
            got_ts_q  <= lnk.tx_ts;
            got_tag_q <= lnk.tx_ts_tag;
         end
         if (lnk.rx_ts_valid)
            got_rx_q <= lnk.rx_ts;
      end
   end

   // read mux; unmapped reads zero
   wire [31:0] rmux;
   assign rmux = (addr == `PTS_REG_CTRL)    ? ctrl_q :
                 (addr == `PTS_REG_STAT)    ? {28'h0000000, stat_q} :
                 (addr == `PTS_REG_MASK)    ? {28'h0000000, mask_q} :
                 (addr == `PTS_REG_TS_LO)   ? got_ts_q[31:0] :
                 (addr == `PTS_REG_TAG)     ? {got_tag_q, tag_q} :
                 (addr == `PTS_REG_ADJ)     ? {21'h000000, adj_q} :
                 (addr == `PTS_REG_RXTS_LO) ? got_rx_q[31:0] : 32'h00000000;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         rdata_q <= '0;
      else
         rdata_q <= rd ? rmux : 32'h00000000;
   end
   assign rdata = rdata_q;
   assign irq   = |(stat_q & mask_q);
endmodule : pts_cli

// ==== testbench/pts_link_assertions.sv ====
// timing checks on the link between the stamping end and the client end
`include "pts_defines.svh"
module pts_link_assertions
(
   // clock and reset
   input wire logic                   clock,
   input wire logic                   sys_rst,
   // transmit side
   input wire logic [`PTS_TS_W-1:0]   tx_ts,
   input wire logic [`PTS_TS_W-1:0]   tx_ins_value,
   input wire logic                   tx_ins_valid,
   input wire logic                   tc_mode,
   input wire logic [`PTS_RXTS_W-1:0] tx_ingress_ts,
   input wire logic [`PTS_ADJ_W-1:0]  tx_lat_adj,
   input wire logic                   tag_wr_err,
   input wire logic                   tag_rd_err,
   // receive side
   input wire logic                   rx_sop,
   input wire logic [`PTS_TS_W-1:0]   rx_timer,
   input wire logic [`PTS_TS_W-1:0]   rx_ts,
   input wire logic                   rx_ts_valid
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // receive stamp: request then answer one cycle later
   sequence s_rx_req;
      rx_sop;
   endsequence
   sequence s_rx_ans;
      rx_ts_valid && (rx_ts == $past(rx_timer));
   endsequence
   a_rx_stamp_follow: assert property (s_rx_req |=> s_rx_ans)
      else $error("receive stamp missing or wrong");
   a_rx_valid_cause: assert property (rx_ts_valid |-> $past(rx_sop))
      else $error("receive valid without packet start");
   a_wr_err_sticky: assert property (tag_wr_err |=> tag_wr_err)
      else $error("tag write error dropped");
   a_rd_err_sticky: assert property (tag_rd_err |=> tag_rd_err)
      else $error("tag read error dropped");
   a_ins_ordinary_value: assert property (tx_ins_valid && !tc_mode
      |-> tx_ins_value == tx_ts)
      else $error("ordinary insert value differs from stamp");
   a_ins_residence_sum: assert property (tx_ins_valid && tc_mode
      |-> tx_ins_value == tx_ts - {16'h0000, tx_ingress_ts})
      else $error("residence correction wrong");
   a_ingress_top_bit: assert property (tx_ingress_ts[63] == 1'b0)
      else $error("ingress stamp top bit set");
   a_adj_reset_value: assert property ($fell(sys_rst) |-> tx_lat_adj == `PTS_TC_ADJ_REC)
      else $error("latency adjust not at recommended value");
endmodule : pts_link_assertions

// ==== testbench/ptp_timestamp_port_logic_tb_top.sv ====
// self-checking bench joining client end and stamping end
`include "pts_defines.svh"
module ptp_timestamp_port_logic_tb_top
   import pts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic        frame_sop = 1'b0;
   logic        rx_frame_sop = 1'b0;
   logic        cap_plane = 1'b0;
   logic [79:0] tx_timer_in = 80'h0;
   logic [79:0] rx_timer_in = 80'h0;
   logic [79:0] got_ts;
   logic [79:0] got_ins;
   logic [15:0] got_tag;
   logic        got_insv;
   int          mismatches = 0;
   int          cmp_count = 0;
   pts_if lnk();
   pts_dev pts_dev_i (.clock(clock), .sys_rst(sys_rst), .lnk(lnk), .cap_plane(cap_plane));
   pts_cli pts_cli_i (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .frame_sop(frame_sop), .tx_timer_in(tx_timer_in),
      .rx_timer_in(rx_timer_in), .rx_frame_sop(rx_frame_sop), .lnk(lnk));
   pts_link_assertions chk (.clock(clock), .sys_rst(sys_rst), .tx_ts(lnk.tx_ts),
      .tx_ins_value(lnk.tx_ins_value), .tx_ins_valid(lnk.tx_ins_valid), .tc_mode(lnk.tc_mode),
      .tx_ingress_ts(lnk.tx_ingress_ts), .tx_lat_adj(lnk.tx_lat_adj),
      .tag_wr_err(lnk.tag_wr_err), .tag_rd_err(lnk.tag_rd_err), .rx_sop(lnk.rx_sop),
      .rx_timer(lnk.rx_timer), .rx_ts(lnk.rx_ts), .rx_ts_valid(lnk.rx_ts_valid));
   // free-running 10 MHz clock
   always #50 clock = ~clock;
   task check(input logic [79:0] seen, input logic [79:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task do_reset(input int n);
      sys_rst <= 1'b1;
      repeat (n) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
   endtask : do_reset
   // strobes end with a spare edge so back-to-back calls never drive twice per step
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask : wr_reg
   task rd_reg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clock);
   endtask : rd_reg
   task frame;
      frame_sop <= 1'b1;
      @(posedge clock);
      frame_sop <= 1'b0;
      @(posedge clock);
   endtask : frame
   // timer is held at t while the frame crosses the capture plane
   task cap(input logic [79:0] t, output logic hit);
      tx_timer_in <= t;
      cap_plane <= 1'b1;
      @(posedge clock);
      cap_plane <= 1'b0;
      hit = 1'b0;
      for (int i = 0; i < 4 && !hit; i++)
      begin
         #1 hit = (lnk.tx_ts_valid === 1'b1) || (lnk.tx_ins_valid === 1'b1);
         got_ts = lnk.tx_ts;
         got_ins = lnk.tx_ins_value;
         got_tag = lnk.tx_ts_tag;
         got_insv = lnk.tx_ins_valid;
         @(posedge clock);
      end
   endtask : cap
   task t_regs;
      logic [31:0] d;
      rd_reg(4'h5, d);
      check(80'(d[10:0]), 80'h322);
      wr_reg(4'hF, 32'hFFFF_FFFF);
      rd_reg(4'hF, d);
      check(80'(d), 80'h0);
   endtask : t_regs
   task t_two_step;
      logic hit;
      wr_reg(4'h2, 32'h1);
      wr_reg(4'h0, 32'({PTS_OP_TWO, 2'b00}));
      wr_reg(4'h4, 32'h0000_1234);
      frame;
      frame;
      cap(80'h11, hit);
      check(80'(hit), 80'h1);
      check(80'(got_tag), 80'h1234);
      check(got_ts, 80'h11);
      check(80'(got_insv), 80'h0);
      cap(80'h22, hit);
      check(80'(got_tag), 80'h1235);
      check(got_ts, 80'h22);
      #1 check(80'(irq), 80'h1);
      wr_reg(4'h1, 32'h1);
      #1 check(80'(irq), 80'h0);
   endtask : t_two_step
   // unqueued actions leave the queue empty, so the capture must fault
   task t_noop;
      logic    hit;
      pts_op_t ops [3];
      ops = '{PTS_OP_NONE, PTS_OP_RSVD, PTS_OP_ONE};
      foreach (ops[k])
      begin
         wr_reg(4'h0, 32'({ops[k], 2'b00}));
         frame;
      end
      cap(80'h33, hit);
      check(80'(hit), 80'h0);
      check(80'(lnk.tag_rd_err), 80'h1);
      do_reset(2);
      check(80'(lnk.tag_rd_err), 80'h0);
   endtask : t_noop
   task t_overflow;
      logic        hit;
      logic [31:0] d;
      wr_reg(4'h0, 32'({PTS_OP_TWO, 2'b00}));
      repeat (`PTS_TAGQ_DEPTH) frame;
      check(80'(lnk.tag_wr_err), 80'h0);
      frame;
      cap(80'h44, hit);
      check(80'(lnk.tag_wr_err), 80'h1);
      rd_reg(4'h1, d);
      check(80'(d[2]), 80'h1);
      do_reset(2);
      check(80'(lnk.tag_wr_err), 80'h0);
   endtask : t_overflow
   task t_one_step;
      logic hit;
      rx_timer_in <= 80'h0000_8000_0000_1234_5678;
      rx_frame_sop <= 1'b1;
      @(posedge clock);
      rx_frame_sop <= 1'b0;
      // the stamp must stand in the cycle right after the packet start, and only then
      @(negedge clock);
      check(80'(lnk.rx_ts_valid), 80'h1);
      check(lnk.rx_ts, 80'h0000_8000_0000_1234_5678);
      @(negedge clock);
      check(80'(lnk.rx_ts_valid), 80'h0);
      repeat (2) @(posedge clock);
      check(80'(lnk.tx_ingress_ts), 80'h1234_5678);
      wr_reg(4'h5, 32'h10);
      wr_reg(4'h0, 32'({PTS_OP_ONE, 2'b10}));
      frame;
      cap(80'h100, hit);
      check(got_ins, 80'h100 + (80'h10 << 13));
      check(got_ts, 80'h100 + (80'h10 << 13));
      check(80'(got_insv), 80'h1);
      wr_reg(4'h5, 32'h322);
      wr_reg(4'h0, 32'({PTS_OP_ONE, 2'b11}));
      frame;
      cap(80'h100, hit);
      check(got_ins, 80'h100 + (80'h322 << 13) - 80'h1234_5678);
   endtask : t_one_step
   // main sequence
   initial
   begin
      do_reset(8);
      t_regs;
      t_two_step;
      t_noop;
      t_overflow;
      t_one_step;
      complete_run;
   end
   // watchdog, far beyond the hundred or so cycles the run needs
   initial
   begin
      #500000;
      mismatches++;
      complete_run;
   end
endmodule : ptp_timestamp_port_logic_tb_top
